// ### svd_pkg.sv
// package: register map, field layout and constants of the supply detector
package svd_pkg;
	localparam logic [1:0] ADDR_CLK = 2'h0;
	localparam logic [1:0] ADDR_CTL = 2'h1;
	localparam logic [1:0] ADDR_FLG = 2'h2;
	localparam logic [1:0] ADDR_IEN = 2'h3;
	// clock control fields
	localparam int DEBUG_RUN_BIT = 8;
	localparam int DIV_LSB = 4;
	localparam int SRC_LSB = 0;
	localparam logic DEBUG_RUN_RST = 1'h1;
	localparam logic [2:0] DIV_RST = 3'h0;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [1:0] SRC_INTERNAL_OSCILLATOR = 2'h0;
	localparam logic [1:0] SRC_LOW = 2'h1;
	localparam logic [1:0] SRC_HIGH = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;
	localparam logic [2:0] DIV_MAX = 3'h5;
	// control fields
	localparam int SUP_BIT = 15;
	localparam int SC_LSB = 13;
	localparam int THR_LSB = 8;
	localparam int KEY_LSB = 4;
	localparam int CYC_LSB = 1;
	localparam int EN_BIT = 0;
	localparam logic [4:0] THR_RST = 5'h1e;
	localparam logic [3:0] KEY_RESET = 4'ha;
	localparam logic [1:0] CYC_CONT = 2'h0;
	// status fields
	localparam int RES_BIT = 8;
	localparam int FLAG_BIT = 0;
	localparam int IE_BIT = 0;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// detector timing
	localparam logic [9:0] PER_128 = 10'h07f;
	localparam logic [9:0] PER_256 = 10'h0ff;
	localparam logic [9:0] PER_512 = 10'h1ff;
	localparam logic [6:0] DIVCNT_MAX = 7'h7f;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [2:0] RST_HOLD = 3'h3;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_STOP = 3'b100
	} svd_state_t;
endpackage : svd_pkg

// ### svd_ctrl.sv
// supply voltage detector digital control
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module svd_ctrl
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic internal_oscillator,
	input wire logic low_speed_oscillator,
	input wire logic high_speed_oscillator,
	input wire logic external_clock_input,
	input wire logic debug_mode,
	input wire logic comparator_low,
	output logic supply_select,
	output logic [4:0] threshold_level,
	output logic detector_power,
	output logic irq,
	output logic svd_reset
);
	// control registers
	logic debug_run_r, debug_run_nxt;
	logic [2:0] clock_divider_r, clock_divider_nxt;
	logic [1:0] clock_source_select_r, clock_source_select_nxt;
	logic supply_select_r, supply_select_nxt;
	logic [1:0] successive_count_r, successive_count_nxt;
	logic [4:0] threshold_level_r, threshold_level_nxt;
	logic [3:0] reset_enable_key_r, reset_enable_key_nxt;
	logic [1:0] detection_cycle_r, detection_cycle_nxt;
	logic detector_enable_r, detector_enable_nxt;
	logic low_voltage_flag_r, low_voltage_flag_nxt;
	logic low_voltage_irq_enable_r, low_voltage_irq_enable_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	// detector engine
	svd_pkg::svd_state_t state_r, state_nxt;
	logic sync1_r, sync2_r, src_d_r;
	logic [6:0] divcnt_r, divcnt_nxt;
	logic [9:0] intv_r, intv_nxt;
	logic [3:0] lowcnt_r, lowcnt_nxt;
	logic result_r, result_nxt;
	logic power_r, power_nxt;
	logic irq_r, irq_nxt;
	logic rst_r, rst_nxt;
	logic [2:0] hold_r, hold_nxt;
	logic reinit;
	logic tick;
	logic trigger;
	logic src_clk;

	function automatic logic [3:0] need_count(input logic [1:0] sc);
		case (sc)
			2'h0: need_count = 4'h1;
			2'h1: need_count = 4'h2;
			2'h2: need_count = 4'h4;
			default: need_count = 4'h8;
		endcase
	endfunction : need_count

	function automatic logic [9:0] period(input logic [1:0] cyc);
		case (cyc)
			2'h1: period = svd_pkg::PER_128;
			2'h2: period = svd_pkg::PER_256;
			default: period = svd_pkg::PER_512;
		endcase
	endfunction : period

	// the source clocks are sampled as plain inputs; edges become ticks
	always_comb
	begin
		case (clock_source_select_r)
			svd_pkg::SRC_INTERNAL_OSCILLATOR: src_clk = internal_oscillator;
			svd_pkg::SRC_LOW: src_clk = low_speed_oscillator;
			svd_pkg::SRC_HIGH: src_clk = high_speed_oscillator;
			default: src_clk = external_clock_input;
		endcase
	end

	// divider: tick on rising source edge once 2^(div+2) edges have passed; low and external sources tick on every edge
	always_comb
	begin
		logic edge_seen;
		logic [6:0] lim;
		edge_seen = src_clk & ~src_d_r;
		lim = 7'((8'h04 << clock_divider_r) - 8'h01);
		if (clock_source_select_r == svd_pkg::SRC_LOW ||
			clock_source_select_r == svd_pkg::SRC_EXT)
		begin
			lim = 7'h00;
		end
		divcnt_nxt = divcnt_r;
		tick = 1'b0;
		if (debug_mode && !debug_run_r)
		begin
			edge_seen = 1'b0;
		end
		if (edge_seen)
		begin
			if (divcnt_r >= lim)
			begin
				divcnt_nxt = 7'h00;
				tick = 1'b1;
			end
			else
			begin
				divcnt_nxt = divcnt_r + 7'h01;
			end
		end
	end

	// register writes and hardware updates
	always_comb
	begin
		logic wclk, wctl, wflg, wien;
		wclk = wr && addr == svd_pkg::ADDR_CLK;
		wctl = wr && addr == svd_pkg::ADDR_CTL;
		wflg = wr && addr == svd_pkg::ADDR_FLG;
		wien = wr && addr == svd_pkg::ADDR_IEN;
		debug_run_nxt = debug_run_r;
		clock_divider_nxt = clock_divider_r;
		clock_source_select_nxt = clock_source_select_r;
		supply_select_nxt = supply_select_r;
		successive_count_nxt = successive_count_r;
		threshold_level_nxt = threshold_level_r;
		reset_enable_key_nxt = reset_enable_key_r;
		detection_cycle_nxt = detection_cycle_r;
		detector_enable_nxt = detector_enable_r;
		low_voltage_flag_nxt = low_voltage_flag_r;
		low_voltage_irq_enable_nxt = low_voltage_irq_enable_r;
		reinit = 1'b0;
		if (wclk)
		begin
			debug_run_nxt = wdata[svd_pkg::DEBUG_RUN_BIT];
			if (wdata[svd_pkg::DIV_LSB +: 3] <= svd_pkg::DIV_MAX)
			begin
				clock_divider_nxt = wdata[svd_pkg::DIV_LSB +: 3];
			end
			clock_source_select_nxt = wdata[svd_pkg::SRC_LSB +: 2];
		end
		if (wctl)
		begin
			supply_select_nxt = wdata[svd_pkg::SUP_BIT];
			if (detection_cycle_r != svd_pkg::CYC_CONT)
			begin
				successive_count_nxt = wdata[svd_pkg::SC_LSB +: 2];
			end
			if (wdata[svd_pkg::THR_LSB +: 5] != 5'h00 &&
				wdata[svd_pkg::THR_LSB +: 5] != 5'h1f)
			begin
				threshold_level_nxt = wdata[svd_pkg::THR_LSB +: 5];
			end
			reset_enable_key_nxt = wdata[svd_pkg::KEY_LSB +: 4];
			detection_cycle_nxt = wdata[svd_pkg::CYC_LSB +: 2];
			if (wdata[svd_pkg::EN_BIT])
			begin
				detector_enable_nxt = 1'b1;
			end
			if (detector_enable_r &&
				(successive_count_nxt != successive_count_r ||
				reset_enable_key_nxt != reset_enable_key_r ||
				detection_cycle_nxt != detection_cycle_r))
			begin
				reinit = 1'b1;
			end
		end
		if (wflg && wdata[svd_pkg::FLAG_BIT])
		begin
			low_voltage_flag_nxt = 1'b0;
			reinit = reinit | detector_enable_r;
		end
		if (wien)
		begin
			low_voltage_irq_enable_nxt = wdata[svd_pkg::IE_BIT];
		end
		// enable clears one cycle after the engine enters its stop state, before the hold count runs out
		if (state_r == svd_pkg::ST_STOP)
		begin
			detector_enable_nxt = 1'b0;
		end
		if (trigger && reset_enable_key_r != svd_pkg::KEY_RESET)
		begin
			low_voltage_flag_nxt = 1'b1;
		end
		if (rst_r)
		begin
			detection_cycle_nxt = svd_pkg::CYC_CONT;
			successive_count_nxt = 2'h0;
			low_voltage_irq_enable_nxt = 1'b0;
			debug_run_nxt = svd_pkg::DEBUG_RUN_RST;
			clock_divider_nxt = svd_pkg::DIV_RST;
			clock_source_select_nxt = svd_pkg::SRC_RST;
		end
	end

	// detector engine
	always_comb
	begin
		logic stop_req;
		logic sampled;
		sampled = 1'b0;
		stop_req = wr && addr == svd_pkg::ADDR_CTL &&
			!wdata[svd_pkg::EN_BIT] && detector_enable_r;
		state_nxt = state_r;
		intv_nxt = intv_r;
		lowcnt_nxt = lowcnt_r;
		result_nxt = result_r;
		power_nxt = power_r;
		hold_nxt = hold_r;
		trigger = 1'b0;
		case (state_r)
			svd_pkg::ST_IDLE:
			begin
				power_nxt = 1'b0;
				if (detector_enable_r)
				begin
					state_nxt = svd_pkg::ST_RUN;
					intv_nxt = 10'h000;
					lowcnt_nxt = 4'h0;
				end
			end
			svd_pkg::ST_RUN:
			begin
				if (stop_req)
				begin
					state_nxt = svd_pkg::ST_STOP;
					hold_nxt = svd_pkg::RST_HOLD;
					power_nxt = 1'b0;
				end
				else if (reinit)
				begin
					intv_nxt = 10'h000;
					lowcnt_nxt = 4'h0;
				end
				else if (detection_cycle_r == svd_pkg::CYC_CONT)
				begin
					power_nxt = 1'b1;
					// comparator plus synchroniser need cycles after power-up
					if (!power_r)
					begin
						hold_nxt = svd_pkg::RST_HOLD;
					end
					else if (hold_r != 3'h0)
					begin
						hold_nxt = hold_r - 3'h1;
					end
					else if (tick)
					begin
						result_nxt = sync2_r;
						trigger = sync2_r;
						sampled = 1'b1;
					end
				end
				else if (tick)
				begin
					// power two slots so the synchronised value has settled
					power_nxt = intv_r <= 10'h001;
					if (intv_r == 10'h002)
					begin
						sampled = 1'b1;
						result_nxt = sync2_r;
						if (!sync2_r)
						begin
							lowcnt_nxt = 4'h0;
						end
						else if (lowcnt_r + svd_pkg::CNT_ONE >=
							need_count(successive_count_r))
						begin
							lowcnt_nxt = 4'h0;
							trigger = 1'b1;
						end
						else
						begin
							lowcnt_nxt = lowcnt_r + svd_pkg::CNT_ONE;
						end
					end
					if (intv_r >= period(detection_cycle_r))
					begin
						intv_nxt = 10'h000;
					end
					else
					begin
						intv_nxt = intv_r + 10'h001;
					end
				end
			end
			svd_pkg::ST_STOP:
			begin
				intv_nxt = 10'h000;
				lowcnt_nxt = 4'h0;
				power_nxt = 1'b0;
				hold_nxt = hold_r - 3'h1;
				if (hold_r == 3'h0)
				begin
					state_nxt = svd_pkg::ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = svd_pkg::ST_IDLE;
			end
		endcase
		// reset stays asserted until a sample of comparator_low reads 0 again
		rst_nxt = rst_r;
		if (trigger && reset_enable_key_r == svd_pkg::KEY_RESET)
		begin
			rst_nxt = 1'b1;
		end
		else if (rst_r && sampled && !sync2_r)
		begin
			rst_nxt = 1'b0;
		end
		// irq suppressed whenever the reset key is armed
		irq_nxt = low_voltage_flag_nxt && low_voltage_irq_enable_nxt &&
			reset_enable_key_nxt != svd_pkg::KEY_RESET;
	end

	always_comb
	begin
		rdata_nxt = svd_pkg::ZERO16;
		if (rd)
		begin
			case (addr)
				svd_pkg::ADDR_CLK:
				begin
					rdata_nxt[svd_pkg::DEBUG_RUN_BIT] = debug_run_r;
					rdata_nxt[svd_pkg::DIV_LSB +: 3] = clock_divider_r;
					rdata_nxt[svd_pkg::SRC_LSB +: 2] = clock_source_select_r;
				end
				svd_pkg::ADDR_CTL:
				begin
					rdata_nxt[svd_pkg::SUP_BIT] = supply_select_r;
					rdata_nxt[svd_pkg::SC_LSB +: 2] = successive_count_r;
					rdata_nxt[svd_pkg::THR_LSB +: 5] = threshold_level_r;
					rdata_nxt[svd_pkg::KEY_LSB +: 4] = reset_enable_key_r;
					rdata_nxt[svd_pkg::CYC_LSB +: 2] = detection_cycle_r;
					rdata_nxt[svd_pkg::EN_BIT] = detector_enable_r;
				end
				svd_pkg::ADDR_FLG:
				begin
					rdata_nxt[svd_pkg::RES_BIT] = result_r;
					rdata_nxt[svd_pkg::FLAG_BIT] = low_voltage_flag_r;
				end
				default:
				begin
					rdata_nxt[svd_pkg::IE_BIT] = low_voltage_irq_enable_r;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			debug_run_r <= svd_pkg::DEBUG_RUN_RST;
			clock_divider_r <= svd_pkg::DIV_RST;
			clock_source_select_r <= svd_pkg::SRC_RST;
			supply_select_r <= 1'b0;
			successive_count_r <= 2'h0;
			threshold_level_r <= svd_pkg::THR_RST;
			reset_enable_key_r <= 4'h0;
			detection_cycle_r <= svd_pkg::CYC_CONT;
			detector_enable_r <= 1'b0;
			low_voltage_flag_r <= 1'b0;
			low_voltage_irq_enable_r <= 1'b0;
			rdata_r <= svd_pkg::ZERO16;
			state_r <= svd_pkg::ST_IDLE;
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			src_d_r <= 1'b0;
			divcnt_r <= 7'h00;
			intv_r <= 10'h000;
			lowcnt_r <= 4'h0;
			result_r <= 1'b0;
			power_r <= 1'b0;
			irq_r <= 1'b0;
			rst_r <= 1'b0;
			hold_r <= 3'h0;
		end
		else if (ce)
		begin
			debug_run_r <= debug_run_nxt;
			clock_divider_r <= clock_divider_nxt;
			clock_source_select_r <= clock_source_select_nxt;
			supply_select_r <= supply_select_nxt;
			successive_count_r <= successive_count_nxt;
			threshold_level_r <= threshold_level_nxt;
			reset_enable_key_r <= reset_enable_key_nxt;
			detection_cycle_r <= detection_cycle_nxt;
			detector_enable_r <= detector_enable_nxt;
			low_voltage_flag_r <= low_voltage_flag_nxt;
			low_voltage_irq_enable_r <= low_voltage_irq_enable_nxt;
			rdata_r <= rdata_nxt;
			state_r <= state_nxt;
			sync1_r <= comparator_low;
			sync2_r <= sync1_r;
			src_d_r <= src_clk;
			divcnt_r <= divcnt_nxt;
			intv_r <= intv_nxt;
			lowcnt_r <= lowcnt_nxt;
			result_r <= result_nxt;
			power_r <= power_nxt;
			irq_r <= irq_nxt;
			rst_r <= rst_nxt;
			hold_r <= hold_nxt;
		end
	end

	assign rdata = rdata_r;
	assign supply_select = supply_select_r;
	assign threshold_level = threshold_level_r;
	assign detector_power = power_r;
	assign irq = irq_r;
	assign svd_reset = rst_r;

	a_reset_no_irq: assert property (@(posedge clk) disable iff (srst)
		svd_reset |-> !irq) else $error("irq with reset");
	a_flag_clear: assert property (@(posedge clk) disable iff (srst)
		ce && wr && addr == svd_pkg::ADDR_FLG && wdata[0] && !trigger
		|=> !low_voltage_flag_r) else $error("flag not cleared");
	a_rst_defaults: assert property (@(posedge clk) disable iff (srst)
		ce && rst_r |=> detection_cycle_r == svd_pkg::CYC_CONT)
		else $error("mode not forced");
	a_irq_gate: assert property (@(posedge clk) disable iff (srst)
		irq |-> low_voltage_irq_enable_r && low_voltage_flag_r)
		else $error("irq ungated");
	a_cont_ignore: assert property (@(posedge clk) disable iff (srst)
		ce && wr && addr == svd_pkg::ADDR_CTL && detection_cycle_r == 2'h0
		&& !rst_r |=> $stable(successive_count_r))
		else $error("count written in continuous");
	a_thr_legal: assert property (@(posedge clk) disable iff (srst)
		threshold_level_r != 5'h00 && threshold_level_r != 5'h1f)
		else $error("bad threshold");
	a_stop_delay: assert property (@(posedge clk) disable iff (srst)
		ce && state_r == svd_pkg::ST_RUN && state_nxt == svd_pkg::ST_STOP
		|=> detector_enable_r) else $error("enable fell early");
	a_sync_pair: assert property (@(posedge clk) disable iff (srst)
		ce |=> sync2_r == $past(sync1_r)) else $error("sync broken");
endmodule : svd_ctrl

// ### svd_afe_model.sv
// behavioural comparator model facing the detector control
`timescale 1ns/1ps
module svd_afe_model
(
	input wire logic clk,
	input wire logic [4:0] core_level,
	input wire logic [4:0] pin_level,
	input wire logic supply_select,
	input wire logic [4:0] threshold_level,
	input wire logic detector_power,
	output logic comparator_low
);
	logic [4:0] level;
	assign level = supply_select ? pin_level : core_level;
	initial comparator_low = 1'h0;
	// unpowered output means nothing, so it wanders instead of holding
	always @(posedge clk)
	begin
		if (detector_power)
			comparator_low <= (level < threshold_level);
		else
			comparator_low <= ~comparator_low;
	end
endmodule : svd_afe_model

// ### tb.sv
// self-checking bench for the supply detector control
`timescale 1ns/1ps
module tb;
	logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, dbg = 1'h0;
	logic [1:0] addr = 2'h0;
	logic [15:0] wdata = 16'h0000, rdata;
	logic osc = 1'h0, cmp_low, sup_sel, pwr, irq, svd_reset, pw_q = 1'h0;
	logic [4:0] thr, core_level = 5'h1f, pin_level = 5'h1f;
	int miscompares = 0, total_checks = 0, pulses = 0, cyc_n = 0;
	svd_ctrl dut (.clk(clk), .srst(srst), .ce(1'h1), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.internal_oscillator(osc), .low_speed_oscillator(osc),
		.high_speed_oscillator(osc), .external_clock_input(osc),
		.debug_mode(dbg), .comparator_low(cmp_low),
		.supply_select(sup_sel), .threshold_level(thr),
		.detector_power(pwr), .irq(irq), .svd_reset(svd_reset));
	svd_afe_model afe (.clk(clk), .core_level(core_level),
		.pin_level(pin_level), .supply_select(sup_sel),
		.threshold_level(thr), .detector_power(pwr),
		.comparator_low(cmp_low));
	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		osc <= ~osc;
		cyc_n <= cyc_n + 1;
		pw_q <= pwr;
		if (pwr && !pw_q)
			pulses <= pulses + 1;
	end
	task wrap_up;
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg
	task rd_reg(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask : rd_reg
	task rd_chk(input logic [1:0] a, input logic [15:0] m, input logic [15:0] e);
		logic [15:0] d;
		rd_reg(a, d);
		chk(d & m, e);
	endtask : rd_chk
	task wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc
	// software must see the enable read back 0 before touching it again
	task stop_det(input logic [15:0] ctl_off);
		logic [15:0] d;
		wr_reg(svd_pkg::ADDR_CTL, ctl_off);
		d = 16'h0001;
		for (int n = 0; n < 50 && d[0] !== 1'h0; n++)
			rd_reg(svd_pkg::ADDR_CTL, d);
		chk(d, ctl_off);
	endtask : stop_det
	task t_reset_vals;
		rd_chk(svd_pkg::ADDR_CLK, 16'hffff, 16'h0100);
		rd_chk(svd_pkg::ADDR_CTL, 16'hffff, 16'h1e00);
		rd_chk(svd_pkg::ADDR_FLG, 16'hfeff, 16'h0000);
		rd_chk(svd_pkg::ADDR_IEN, 16'hffff, 16'h0000);
		chk(thr, 16'h001e);
	endtask : t_reset_vals
	task t_fields;
		wr_reg(svd_pkg::ADDR_CTL, 16'h8500);
		rd_chk(svd_pkg::ADDR_CTL, 16'hffff, 16'h8500);
		chk({sup_sel, thr}, 16'h0025);
		wr_reg(svd_pkg::ADDR_CTL, 16'h9f00);
		rd_chk(svd_pkg::ADDR_CTL, 16'hffff, 16'h8500);
		wr_reg(svd_pkg::ADDR_CTL, 16'ha500);
		rd_chk(svd_pkg::ADDR_CTL, 16'hffff, 16'h8500);
		wr_reg(svd_pkg::ADDR_CLK, 16'h0060);
		rd_chk(svd_pkg::ADDR_CLK, 16'hffff, 16'h0000);
		for (int s = 0; s < 4; s++)
		begin
			wr_reg(svd_pkg::ADDR_CLK, 16'h0050 | 16'(s));
			rd_chk(svd_pkg::ADDR_CLK, 16'hffff, 16'h0050 | 16'(s));
		end
		wr_reg(svd_pkg::ADDR_CLK, 16'hfe8f);
		rd_chk(svd_pkg::ADDR_CLK, 16'hffff, 16'h0003);
		wr_reg(svd_pkg::ADDR_IEN, 16'hffff);
		rd_chk(svd_pkg::ADDR_IEN, 16'hffff, 16'h0001);
		wr_reg(svd_pkg::ADDR_IEN, 16'h0000);
		wr_reg(svd_pkg::ADDR_CLK, 16'h0100);
		wr_reg(svd_pkg::ADDR_CTL, 16'h1e00);
	endtask : t_fields
	task t_continuous;
		wr_reg(svd_pkg::ADDR_FLG, 16'h0001);
		wr_reg(svd_pkg::ADDR_IEN, 16'h0001);
		wr_reg(svd_pkg::ADDR_CTL, 16'h1001);
		wait_cyc(200);
		rd_chk(svd_pkg::ADDR_FLG, 16'hffff, 16'h0000);
		core_level <= 5'h02;
		for (int n = 0; n < 2000 && irq !== 1'h1; n++)
			wait_cyc(1);
		chk(irq, 16'h0001);
		rd_chk(svd_pkg::ADDR_FLG, 16'hffff, 16'h0101);
		wr_reg(svd_pkg::ADDR_IEN, 16'h0000);
		wait_cyc(2);
		chk(irq, 16'h0000);
		wr_reg(svd_pkg::ADDR_IEN, 16'h0001);
		core_level <= 5'h1f;
		wait_cyc(300);
		wr_reg(svd_pkg::ADDR_FLG, 16'h0000);
		rd_chk(svd_pkg::ADDR_FLG, 16'hffff, 16'h0001);
		wr_reg(svd_pkg::ADDR_FLG, 16'h0001);
		wait_cyc(2);
		chk(irq, 16'h0000);
		stop_det(16'h1000);
	endtask : t_continuous
	task t_intermittent;
		int t1;
		int p;
		wr_reg(svd_pkg::ADDR_CLK, 16'h0001);
		pin_level <= 5'h02;
		wr_reg(svd_pkg::ADDR_CTL, 16'h9002);
		wr_reg(svd_pkg::ADDR_CTL, 16'hb003);
		p = pulses;
		for (int n = 0; n < 1000 && pulses == p; n++)
			wait_cyc(1);
		t1 = cyc_n;
		wait_cyc(40);
		rd_chk(svd_pkg::ADDR_FLG, 16'hffff, 16'h0100);
		for (int n = 0; n < 1000 && pulses == p + 1; n++)
			wait_cyc(1);
		chk(16'(cyc_n - t1), 16'd256);
		for (int n = 0; n < 200 && irq !== 1'h1; n++)
			wait_cyc(1);
		chk({irq, 15'(pulses - p)}, 16'h8002);
		dbg <= 1'h1;
		p = pulses;
		wait_cyc(600);
		chk(16'(pulses - p), 16'h0000);
		wr_reg(svd_pkg::ADDR_CLK, 16'h0101);
		wait_cyc(600);
		chk(16'(pulses != p), 16'h0001);
		dbg <= 1'h0;
		pin_level <= 5'h1f;
		stop_det(16'hb002);
		wr_reg(svd_pkg::ADDR_FLG, 16'h0001);
	endtask : t_intermittent
	task t_reset_key;
		wr_reg(svd_pkg::ADDR_IEN, 16'h0001);
		wr_reg(svd_pkg::ADDR_CLK, 16'h0011);
		wr_reg(svd_pkg::ADDR_CTL, 16'h30a2);
		core_level <= 5'h02;
		wr_reg(svd_pkg::ADDR_CTL, 16'h30a3);
		for (int n = 0; n < 3000 && svd_reset !== 1'h1; n++)
			wait_cyc(1);
		chk({svd_reset, irq}, 16'h0002);
		rd_chk(svd_pkg::ADDR_CLK, 16'hffff, 16'h0100);
		rd_chk(svd_pkg::ADDR_CTL, 16'hffff, 16'h10a1);
		rd_chk(svd_pkg::ADDR_IEN, 16'hffff, 16'h0000);
		rd_chk(svd_pkg::ADDR_FLG, 16'h0001, 16'h0000);
		chk(svd_reset, 16'h0001);
		core_level <= 5'h1f;
		for (int n = 0; n < 2000 && svd_reset !== 1'h0; n++)
			wait_cyc(1);
		chk(svd_reset, 16'h0000);
		stop_det(16'h10a0);
		wr_reg(svd_pkg::ADDR_FLG, 16'h0001);
		rd_chk(svd_pkg::ADDR_FLG, 16'h0001, 16'h0000);
	endtask : t_reset_key
	initial
	begin
		wait_cyc(10);
		srst <= 1'h0;
		t_reset_vals();
		t_fields();
		t_continuous();
		t_intermittent();
		t_reset_key();
		wrap_up();
	end
	// the tests take about 2.5k cycles; 50k means something hung
	initial
	begin
		#250000;
		miscompares++;
		wrap_up();
	end
endmodule : tb
